/* File: hdl/swdt_pkg.sv */
// Shared constants and state type of the system watchdog timer
package swdt_pkg;
  // Count, reload and prescaler widths
  localparam int CNT_W = 16;
  localparam int RELOAD_W = 8;
  localparam int LOW_W = CNT_W - RELOAD_W;
  localparam int PRE_W = 14;

  // Last prescaler state for each ratio: divide by 16384 or by 256
  localparam logic [PRE_W-1:0] PRE_LAST_SLOW = 14'h3FFF;
  localparam logic [PRE_W-1:0] PRE_LAST_FAST = 14'h00FF;
  localparam logic [PRE_W-1:0] PRE_ZERO = 14'h0000;
  localparam logic [PRE_W-1:0] PRE_ONE = 14'h0001;

  // Reset defaults: divide by 256, reload FF, 256 counts of 256 clocks, about 6.5 ms at 10 MHz
  localparam logic RATIO_SLOW_RST = 1'b0;
  localparam logic [RELOAD_W-1:0] RELOAD_RST = 8'hFF;
  localparam logic ENABLE_RST = 1'b1;

  // Counter constants
  localparam logic [LOW_W-1:0] LOW_LOAD = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ALL_ONES = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  // Counter leaves reset at the default reload point, so the first interval is the default one
  localparam logic [CNT_W-1:0] CNT_RST = 16'hFF00;

  // Cycles from prewarning interrupt to reset request
  localparam int WARN_CYCLES = 16;
  localparam int WARN_W = 8;

  // Watchdog phase, Gray coded along run, warn, reset
  typedef enum logic [1:0]
  {
    SWDT_RUN = 2'b00,
    SWDT_WARN = 2'b01,
    SWDT_RESET = 2'b11
  } swdt_state_t;
endpackage

/* File: hdl/swdt_prescaler.sv */
// Clock prescaler of the watchdog with selectable ratio and synchronous clear
`timescale 1ns/1ps
module swdt_prescaler #(
  parameter int PRE_W = swdt_pkg::PRE_W
)(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic clear,
  input wire logic slowRatio,
  // Status
  output logic tick,
  output logic [PRE_W-1:0] preCount
);
  logic [PRE_W-1:0] preCnt_r;
  logic [PRE_W-1:0] preCnt_nxt;
  wire logic [PRE_W-1:0] lastVal = slowRatio ? swdt_pkg::PRE_LAST_SLOW : swdt_pkg::PRE_LAST_FAST;
  wire logic atLast = (preCnt_r >= lastVal);

  // Tick on the last state; clear wins so a service restarts a full period
  assign tick = run && atLast && !clear;
  assign preCnt_nxt = clear ? swdt_pkg::PRE_ZERO :
                      !run ? preCnt_r :
                      atLast ? swdt_pkg::PRE_ZERO : preCnt_r + swdt_pkg::PRE_ONE;
  assign preCount = preCnt_r;

  // Prescaler state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      preCnt_r <= swdt_pkg::PRE_ZERO;
    else
      preCnt_r <= preCnt_nxt;
  end

  AST_TICK_CLEARS: assert property (@(posedge clk) disable iff (!nrst)
    tick |=> preCnt_r == swdt_pkg::PRE_ZERO)
    else $error("Prescaler did not restart after its tick");
endmodule

/* File: hdl/swdt_top.sv */
// System watchdog timer: 16-bit counter, prescaler, prewarning and reset request
// What this block does
// RL1: After every reset the watchdog comes up running without software action.
// RL2: Disable instruction stops counting, enable resumes it, each accepted anytime, enable winning over a disable in the same cycle.
// RL3: Software services the watchdog before the counter overflows.
// RL4: On overflow a prewarning interrupt comes first, then a reset request.
// RL5: The watchdog count register is 16 bits wide.
// RL6: Counter advances once per prescaler period, dividing by 16384 or 256.
// RL7: The counter is loaded from a software-programmable reload value.
// RL8: Service loads the reload value and clears the prescaler together.
// RL9: Reset defaults give about 6.5 ms interval at 10 MHz.
// RL10: Counter counts up from reload and overflows when wrapping past all ones.
`timescale 1ns/1ps
module swdt_top #(
  parameter int WARN_CYCLES = swdt_pkg::WARN_CYCLES
)(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Instruction strobes from the core decoder
  input wire logic watchdogServiceInstr,
  input wire logic watchdogDisableInstr,
  input wire logic watchdogEnableInstr,
  // Configuration write from the core
  input wire logic cfgWrite,
  input wire logic [swdt_pkg::RELOAD_W-1:0] cfgReloadValue,
  input wire logic cfgSlowRatio,
  // Events toward interrupt and reset control
  output logic prewarnIrq,
  output logic resetReq,
  // Status
  output logic [swdt_pkg::CNT_W-1:0] wdtCount,
  output logic wdtRunning,
  output logic [swdt_pkg::RELOAD_W-1:0] watchdogReloadValue,
  output logic slowRatio
);
  swdt_pkg::swdt_state_t state_r;
  swdt_pkg::swdt_state_t state_nxt;
  logic [swdt_pkg::CNT_W-1:0] count_r;
  logic [swdt_pkg::CNT_W-1:0] count_nxt;
  logic enabled_r;
  logic enabled_nxt;
  logic [swdt_pkg::RELOAD_W-1:0] reload_r;
  logic slow_r;
  logic prewarn_r;
  logic resetReq_r;
  logic [swdt_pkg::WARN_W-1:0] warnCnt_r;
  logic [swdt_pkg::WARN_W-1:0] warnCnt_nxt;
  logic tick;
  logic [swdt_pkg::PRE_W-1:0] preCount;

  localparam logic [swdt_pkg::WARN_W-1:0] WARN_LAST = swdt_pkg::WARN_W'(WARN_CYCLES - 1);
  localparam logic [swdt_pkg::WARN_W-1:0] WARN_ZERO = 8'h00;
  localparam logic [swdt_pkg::WARN_W-1:0] WARN_ONE = 8'h01;

  // Decode of the current phase and events
  wire logic inRun = (state_r == swdt_pkg::SWDT_RUN);
  wire logic inWarn = (state_r == swdt_pkg::SWDT_WARN);
  // Service is ignored once overflow happened: the reset cannot be talked out of
  wire logic doService = watchdogServiceInstr && inRun;
  wire logic overflow = tick && (count_r == swdt_pkg::CNT_ALL_ONES);
  wire logic [swdt_pkg::CNT_W-1:0] loadVal = {reload_r, swdt_pkg::LOW_LOAD};
  wire logic warnDone = inWarn && (warnCnt_r == WARN_LAST);

  // RL6 prescaler feed
  swdt_prescaler #(
    .PRE_W(swdt_pkg::PRE_W)
  ) uPrescaler (
    .clk(clk),
    .nrst(nrst),
    .run(enabled_r && inRun),
    .clear(doService),
    .slowRatio(slow_r),
    .tick(tick),
    .preCount(preCount)
  );

  // RL2 enable control
  // Enable wins a tie so a confused decoder never leaves the watchdog off
  assign enabled_nxt = watchdogEnableInstr ? 1'b1 :
                       watchdogDisableInstr ? 1'b0 : enabled_r;

  // RL8 service reload
  // RL10 count up and wrap
  assign count_nxt = doService ? loadVal :
                     overflow ? loadVal :
                     tick ? count_r + swdt_pkg::CNT_ONE : count_r;

  // RL4 warn then reset
  assign state_nxt = (inRun && overflow) ? swdt_pkg::SWDT_WARN :
                     warnDone ? swdt_pkg::SWDT_RESET : state_r;
  assign warnCnt_nxt = inWarn ? warnCnt_r + WARN_ONE : WARN_ZERO;

  // RL1 running after reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      enabled_r <= swdt_pkg::ENABLE_RST;
    else
      enabled_r <= enabled_nxt;
  end

  // RL7 reload value and ratio
  // RL9 reset defaults
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reload_r <= swdt_pkg::RELOAD_RST;
      slow_r <= swdt_pkg::RATIO_SLOW_RST;
    end
    else if (cfgWrite)
    begin
      reload_r <= cfgReloadValue;
      slow_r <= cfgSlowRatio;
    end
  end

  // RL5 16-bit count register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      count_r <= swdt_pkg::CNT_RST;
    else
      count_r <= count_nxt;
  end

  // Phase, warning timer and event outputs
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= swdt_pkg::SWDT_RUN;
      warnCnt_r <= WARN_ZERO;
      prewarn_r <= 1'b0;
      resetReq_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      warnCnt_r <= warnCnt_nxt;
      prewarn_r <= inRun && overflow;
      resetReq_r <= (state_nxt == swdt_pkg::SWDT_RESET);
    end
  end

  // Outputs, all from flip-flops except wdtRunning, which gates enabled_r with the run phase
  assign prewarnIrq = prewarn_r;
  assign resetReq = resetReq_r;
  assign wdtCount = count_r;
  assign wdtRunning = enabled_r && inRun;
  assign watchdogReloadValue = reload_r;
  assign slowRatio = slow_r;

  AST_UP_AFTER_RESET: assert property (@(posedge clk) // RL1
    $rose(nrst) |-> enabled_r && inRun && !resetReq_r)
    else $error("Watchdog not running after reset");

  AST_DISABLE_STOPS: assert property (@(posedge clk) disable iff (!nrst) // RL2
    watchdogDisableInstr && !watchdogEnableInstr |=> !enabled_r)
    else $error("Disable instruction not taken");

  AST_ENABLE_RESUMES: assert property (@(posedge clk) disable iff (!nrst) // RL2
    watchdogEnableInstr |=> enabled_r ##1 (enabled_r || $past(watchdogDisableInstr)))
    else $error("Enable instruction not taken");

  AST_FROZEN_WHILE_OFF: assert property (@(posedge clk) disable iff (!nrst) // RL2
    !enabled_r && !watchdogServiceInstr |=> $stable(count_r) && !prewarn_r)
    else $error("Counter moved while disabled");

  AST_WARN_ON_OVF: assert property (@(posedge clk) disable iff (!nrst) // RL4
    inRun && overflow |=> prewarn_r && !resetReq_r ##1 !prewarn_r)
    else $error("Overflow without single prewarning pulse");

  AST_RESET_AFTER_WARN: assert property (@(posedge clk) disable iff (!nrst) // RL4
    prewarn_r |-> !resetReq_r ##[1:1000] resetReq_r)
    else $error("Reset request missing after prewarning");

  AST_NO_RESET_UNWARNED: assert property (@(posedge clk) disable iff (!nrst) // RL4
    $rose(resetReq_r) |-> $past(inWarn))
    else $error("Reset request without prewarning phase");

  AST_TICK_ADVANCES: assert property (@(posedge clk) disable iff (!nrst) // RL6
    tick && !doService && count_r != swdt_pkg::CNT_ALL_ONES |=> count_r == $past(count_r) + swdt_pkg::CNT_ONE)
    else $error("Counter did not advance on prescaler tick");

  AST_NO_TICK_NO_MOVE: assert property (@(posedge clk) disable iff (!nrst) // RL6
    !tick && !doService |=> $stable(count_r))
    else $error("Counter moved without prescaler tick");

  AST_SERVICE_LOAD: assert property (@(posedge clk) disable iff (!nrst) // RL8
    doService |=> count_r == {$past(reload_r), swdt_pkg::LOW_LOAD} && preCount == swdt_pkg::PRE_ZERO)
    else $error("Service did not reload counter and clear prescaler");

  AST_WRAP_RELOAD: assert property (@(posedge clk) disable iff (!nrst) // RL10
    overflow && !doService |=> count_r == {$past(reload_r), swdt_pkg::LOW_LOAD})
    else $error("Overflow did not reload from reload value");

  AST_DEFAULTS: assert property (@(posedge clk) // RL9
    $rose(nrst) |-> reload_r == swdt_pkg::RELOAD_RST && slow_r == swdt_pkg::RATIO_SLOW_RST)
    else $error("Reset defaults wrong");

  COV_SERVICE: cover property (@(posedge clk) disable iff (!nrst) doService && count_r != loadVal);
  COV_OVERFLOW: cover property (@(posedge clk) disable iff (!nrst) prewarn_r);
  COV_RESET: cover property (@(posedge clk) disable iff (!nrst) $rose(resetReq_r));
  COV_DISABLE: cover property (@(posedge clk) disable iff (!nrst) !enabled_r ##1 enabled_r);
endmodule

/* File: test/swdt_core_model.sv */
// Core-side model that issues the watchdog service strobe after a lag
`timescale 1ns/1ps
module swdt_core_model (
  // Clock
  input wire logic clk,
  // Request and lag from the bench
  input wire logic req,
  input wire logic [7:0] lag,
  // Service strobe toward the watchdog
  output logic svc
);
  // Strobe moves on falling edges so the watchdog samples it cleanly; one process owns it
  // service before overflow
  initial
  begin
    svc = 1'h0;
    forever
    begin
      @(posedge req);
      repeat (lag) @(negedge clk);
      svc = 1'h1;
      @(negedge clk);
      svc = 1'h0;
    end
  end
endmodule

/* File: test/system_watchdog_timer_tb_top.sv */
// Self-checking bench of the system watchdog timer
`timescale 1ns/1ps
module system_watchdog_timer_tb_top;
  // Short warn phase keeps the overflow run brief
  localparam int WC = 2;
  logic clk, nrst, svcReq, svc, dis, ena, cfgWrite, cfgSlowRatio;
  logic prewarnIrq, resetReq, wdtRunning, slowRatio;
  logic [7:0] lag, cfgReloadValue, watchdogReloadValue;
  logic [15:0] wdtCount;
  int num_errors = 0;
  int n_compared = 0;

  swdt_top #(.WARN_CYCLES(WC)) dut (.clk(clk), .nrst(nrst), .watchdogServiceInstr(svc),
    .watchdogDisableInstr(dis), .watchdogEnableInstr(ena), .cfgWrite(cfgWrite),
    .cfgReloadValue(cfgReloadValue), .cfgSlowRatio(cfgSlowRatio), .prewarnIrq(prewarnIrq),
    .resetReq(resetReq), .wdtCount(wdtCount), .wdtRunning(wdtRunning),
    .watchdogReloadValue(watchdogReloadValue), .slowRatio(slowRatio));
  swdt_core_model core (.clk(clk), .req(svcReq), .lag(lag), .svc(svc));

  // 200 MHz system clock
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One-cycle strobe launched on a falling edge
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge clk);
    s = 1'h0;
  endtask

  // Returns at the falling edge just after the strobe was taken
  task automatic service(input logic [7:0] l);
    lag = l;
    svcReq = 1'h1;
    @(negedge svc);
    svcReq = 1'h0;
  endtask

  task automatic cfg(input logic [7:0] r, input logic s);
    cfgReloadValue = r;
    cfgSlowRatio = s;
    pulse(cfgWrite);
    chk("reload out", watchdogReloadValue, r);
    chk("ratio out", slowRatio, s);
  endtask

  // Reset values, then the first step one prescaler period later
  task automatic t_reset();
    nrst = 1'h0;
    repeat (20) @(negedge clk);
    nrst = 1'h1;
    @(negedge clk);
    chk("running", wdtRunning, 1'h1);
    chk("count", wdtCount, 16'hFF00);
    chk("reload", watchdogReloadValue, 8'hFF);
    chk("ratio", slowRatio, 1'h0);
    chk("events", {prewarnIrq, resetReq}, 2'h0);
    repeat (248) @(negedge clk);
    chk("count early", wdtCount, 16'hFF00);
    repeat (10) @(negedge clk);
    chk("count step", wdtCount, 16'hFF01);
  endtask

  // Prescaler is not zero here, so a missed clear shows as an early step
  task automatic t_step(input logic [7:0] r, input logic [7:0] l, input int div);
    service(l);
    chk("reloaded", wdtCount, {r, 8'h00});
    repeat (div - 6) @(negedge clk);
    chk("held", wdtCount, {r, 8'h00});
    repeat (10) @(negedge clk);
    chk("stepped", wdtCount, {r, 8'h01});
  endtask

  task automatic t_disable();
    pulse(dis);
    chk("stopped", wdtRunning, 1'h0);
    repeat (600) @(negedge clk);
    chk("frozen", wdtCount, 16'hA501);
    dis = 1'h1;
    pulse(ena);
    dis = 1'h0;
    chk("resumed", wdtRunning, 1'h1);
  endtask

  // Unserviced run to overflow; a late service must not cancel it
  task automatic t_overflow();
    int n = 0;
    service(8'h00);
    while (prewarnIrq !== 1'h1 && n < 70000)
    begin
      @(negedge clk);
      n++;
    end
    chk("interval", n, 65536);
    chk("wrapped", wdtCount, 16'hFF00);
    service(8'h00);
    chk("warn phase", {prewarnIrq, resetReq}, 2'h0);
    chk("ignored", wdtCount, 16'hFF00);
    repeat (WC - 1) @(negedge clk);
    chk("reset req", resetReq, 1'h1);
  endtask

  initial
  begin
    {svcReq, dis, ena, cfgWrite, cfgSlowRatio} = 5'h00;
    lag = 8'h00;
    cfgReloadValue = 8'h00;
    t_reset();
    cfg(8'hA5, 1'h0);
    t_step(8'hA5, 8'h05, 256);
    t_disable();
    cfg(8'h12, 1'h1);
    t_step(8'h12, 8'h00, 16384);
    cfg(8'hFF, 1'h0);
    t_overflow();
    t_reset();
    end_of_test();
  end

  // Hang guard sized above the longest expected run
  initial
  begin
    #(95000 * 5);
    num_errors++;
    end_of_test();
  end
endmodule
